// >>> tb/seq_table_properties.sv
// checker: port-level properties of the sequencer table store
`timescale 1ns/100ps
module seq_table_properties
	import seq_table_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic tableClearRequest,
	input wire logic writeOnlySegmentPresent,
	input wire logic cmdValid,
	input wire logic cmdReady,
	input wire seq_table_pkg::cmd_t cmd,
	input wire logic cmdError,
	input wire logic wrValid,
	input wire logic wrReady,
	input wire seq_table_pkg::entry_t wrEntry,
	input wire logic rdValid,
	input wire logic rdReady,
	input wire seq_table_pkg::entry_t rdEntry,
	input wire seq_table_pkg::decoded_t rdDecoded,
	input wire logic busy
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	// ****************************************
	// command steps
	// ****************************************
	sequence sTake;
		cmdValid && cmdReady;
	endsequence
	sequence sGoodRead;
		sTake ##0 (cmd.op == OP_READ && !writeOnlySegmentPresent && cmd.length == 20'h1 && cmd.index <= LAST_INDEX);
	endsequence
	a_read_refused: assert property (sTake ##0 (cmd.op == OP_READ && writeOnlySegmentPresent) |=> cmdError)
		else $error("read not refused");
	a_read_answer: assert property (sGoodRead |-> ##2 rdValid)
		else $error("read entry late");
	a_zero_len: assert property (sTake ##0 (cmd.length == 20'h0) |=> cmdError && !busy)
		else $error("empty command accepted");
	// back-to-back refused commands may legally keep the error high
	a_err_pulse: assert property (cmdError && !(cmdValid && cmdReady) |=> !cmdError)
		else $error("error longer than a cycle");
	a_clear_block: assert property (tableClearRequest |=> !cmdReady)
		else $error("command accepted while clear pending");
	a_cfg_action: assert property (rdValid && rdDecoded.kind == KIND_CONFIG
		|-> rdDecoded.actionId == rdEntry[2][31:16])
		else $error("action id wrong");
	a_read_hold: assert property (rdValid && !rdReady |=> rdValid && $stable(rdEntry))
		else $error("read entry dropped");
	a_class_bit: assert property (rdValid
		|-> (rdDecoded.kind == KIND_DATA) == !rdEntry[W_CONTROL][CTL_COMMAND])
		else $error("class decode wrong");
	a_seq_flags: assert property (rdValid |-> {rdDecoded.seqEnd, rdDecoded.scenEnd, rdDecoded.seqInit}
		== rdEntry[0][30:28])
		else $error("marker flags wrong");
	a_idle_kind: assert property (rdValid && rdEntry[0][31] && rdEntry[2][15:0] == CMD_IDLE
		|-> rdDecoded.kind == KIND_IDLE)
		else $error("idle command not decoded");
	a_seg_id: assert property (rdValid && rdDecoded.kind == KIND_DATA |-> rdDecoded.segmentId == rdEntry[3][18:0])
		else $error("segment id wrong");
	a_adv_reserved: assert property (rdValid
		|-> rdDecoded.seqAdvReserved == (rdEntry[0][23:20] > ADV_LAST_DEFINED))
		else $error("advance code check wrong");
endmodule // seq_table_properties

bind seq_table_store seq_table_properties chk_u (.clk, .rst_n, .tableClearRequest, .writeOnlySegmentPresent, .cmdValid,
	.cmdReady, .cmd, .cmdError, .wrValid, .wrReady, .wrEntry, .rdValid, .rdReady, .rdEntry, .rdDecoded, .busy);

// >>> tb/sequencer_table_entry_store_bench.sv
// testbench: write, read, refusal and clear scenarios
`timescale 1ns/100ps
module sequencer_table_entry_store_bench;
	import seq_table_pkg::*;
	logic clk = 1'b0, rst_n = 1'b0, tableClearRequest = 1'b0, writeOnlySegmentPresent = 1'b0;
	logic cmdValid = 1'b0, wrValid = 1'b0, stall = 1'b0;
	logic cmdReady, cmdError, wrReady, rdValid, rdReady, busy;
	cmd_t cmd = '0;
	entry_t wrEntry = '0, rdEntry;
	decoded_t rdDecoded;
	entry_t ents[3];
	int n_fail = 0, n_tests = 0, cycles = 0;
	seq_table_store dut_u (.clk, .rst_n, .tableClearRequest, .writeOnlySegmentPresent, .cmdValid, .cmdReady, .cmd,
		.cmdError, .wrValid, .wrReady, .wrEntry, .rdValid, .rdReady, .rdEntry, .rdDecoded, .busy);
	table_host host_u (.clk, .stall, .rdValid, .rdReady, .rdEntry, .rdDecoded);
	always #2 clk = ~clk;
	task automatic finish_test;
		$display("tests %0d fails %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// hang guard, well above the fewer than a hundred cycles needed
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			n_fail++;
			finish_test;
		end
	end
	task automatic chk(input string name, input logic [191:0] exp, got);
		n_tests++;
		if (got !== exp)
		begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask
	// one command; err sampled in the cycle after the taking edge
	task automatic send(input op_t op, input int idx, len, output logic err);
		@(negedge clk);
		cmdValid = 1'b1;
		cmd = {op, idx[18:0], len[19:0]};
		while (!cmdReady) @(negedge clk);
		@(negedge clk);
		cmdValid = 1'b0;
		err = cmdError;
	endtask
	// write run of n entries taken from ents, one beat each
	task automatic put(input int idx, n);
		logic err;
		send(OP_WRITE, idx, n, err);
		chk("wrErr", 0, err);
		wrValid = 1'b1;
		for (int i = 0; i < n; i++)
		begin
			wrEntry = ents[i];
			while (!wrReady) @(negedge clk);
			@(negedge clk);
		end
		wrValid = 1'b0;
	endtask
	task automatic t_write_read;
		logic err;
		ents[0] = {32'hFFFFFFFF, 32'h000000F0, 32'h00000003, 32'h00000002, 32'h00000007, 32'h11120000};
		ents[1] = {32'h00000000, 32'h000003C0, 32'h0000005A, 32'h00000000, 32'h00000001, 32'h8000C000};
		ents[2] = {32'h000000EF, 32'h00000000, 32'h00000005, 32'h00020001, 32'h00000001, 32'h81030000};
		put(524284, 3);
		stall = 1'b1;
		send(OP_READ, 524284, 3, err);
		chk("rdErr", 0, err);
		repeat (5) @(negedge clk);
		chk("rdValid", 1, rdValid);
		stall = 1'b0;
		for (int k = 0; k < 20 && host_u.gotEntry.size() < 3; k++) @(negedge clk);
		foreach (ents[i]) chk("entry", ents[i], host_u.gotEntry[i]);
		chk("kind0", KIND_DATA, host_u.gotDecoded[0].kind);
		chk("seqLoop", 7, host_u.gotDecoded[0].seqLoop);
		chk("segLoop", 2, host_u.gotDecoded[0].segLoop);
		chk("segAdv", ADV_REPEAT, host_u.gotDecoded[0].segAdv);
		chk("marker", 1, host_u.gotDecoded[0].markerEn);
		chk("endLast", 1, host_u.gotDecoded[0].endIsLast);
		chk("kind1", KIND_IDLE, host_u.gotDecoded[1].kind);
		chk("idleSample", 32'h0000005A, host_u.gotDecoded[1].idleSample);
		chk("ampStep", 2'h3, {host_u.gotDecoded[1].ampInit, host_u.gotDecoded[1].ampInc});
		chk("kind2", KIND_CONFIG, host_u.gotDecoded[2].kind);
		chk("actionId", 16'h0002, host_u.gotDecoded[2].actionId);
		chk("segAdv2", ADV_SINGLE, host_u.gotDecoded[2].segAdv);
		chk("seqLoop2", 0, host_u.gotDecoded[2].seqLoop);
		chk("marker2", 1, host_u.gotDecoded[2].markerEn);
		chk("segId2", 5, host_u.gotDecoded[2].segmentId);
		chk("endLast2", 0, host_u.gotDecoded[2].endIsLast);
	endtask
	task automatic t_refuse;
		logic err;
		writeOnlySegmentPresent = 1'b1;
		send(OP_READ, 0, 1, err);
		chk("rdRefused", 1, err);
		writeOnlySegmentPresent = 1'b0;
		send(OP_WRITE, 524285, 3, err);
		chk("overRun", 1, err);
		send(OP_WRITE, 524287, 1, err);
		chk("badIndex", 1, err);
		send(OP_WRITE, 0, 0, err);
		chk("zeroLen", 1, err);
	endtask
	// full walk is too long to run; only its start is seen
	task automatic t_clear;
		logic err;
		put(0, 1);
		tableClearRequest = 1'b1;
		@(negedge clk);
		tableClearRequest = 1'b0;
		repeat (3) @(negedge clk);
		chk("clrBusy", 1, busy);
		chk("clrReady", 0, cmdReady);
		rst_n = 1'b0;
		@(negedge clk);
		rst_n = 1'b1;
		chk("rstBusy", 0, busy);
		// walk cut short, but entry 0 was already put back to default
		send(OP_READ, 0, 1, err);
		chk("rdErr0", 0, err);
		for (int k = 0; k < 20 && host_u.gotEntry.size() < 4; k++) @(negedge clk);
		chk("cleared", DEF_ENTRY, host_u.gotEntry[3]);
	endtask
	initial
	begin
		repeat (6) @(negedge clk);
		rst_n = 1'b1;
		t_write_read;
		t_refuse;
		t_clear;
		finish_test;
	end
endmodule // sequencer_table_entry_store_bench

// >>> tb/table_host.sv
// partner: host-side consumer of read entries, with a stall control
`timescale 1ns/100ps
module table_host
	import seq_table_pkg::*;
(
	input wire logic clk,
	input wire logic stall,
	input wire logic rdValid,
	output logic rdReady = 1'b0,
	input wire seq_table_pkg::entry_t rdEntry,
	input wire seq_table_pkg::decoded_t rdDecoded
);
	entry_t gotEntry[$];
	decoded_t gotDecoded[$];
	always @(posedge clk)
	begin
		if (rdValid && rdReady)
		begin
			gotEntry.push_back(rdEntry);
			gotDecoded.push_back(rdDecoded);
		end
		rdReady <= !stall;
	end
endmodule // table_host

// >>> verilog/seq_table_pkg.sv
// package: sequencer table entry layout, field positions, codes and limits
package seq_table_pkg;
	// ****************************************
	// table geometry
	// ****************************************
	localparam int ENTRY_COUNT = 524287;
	localparam int INDEX_W = 19;
	localparam int WORDS_PER_ENTRY = 6;
	localparam int WORD_W = 32;
	localparam logic [INDEX_W-1:0] LAST_INDEX = 19'h7FFFE;
	localparam logic [INDEX_W:0] ENTRY_COUNT_V = 20'h7FFFF;

	// ****************************************
	// word positions inside an entry
	// ****************************************
	localparam int W_CONTROL = 0;
	localparam int W_SEQ_LOOP = 1;
	localparam int W_SEG_LOOP = 2;
	localparam int W_CMD_CODE = 2;
	localparam int W_SEG_ID_DATA = 3;
	localparam int W_IDLE_SAMPLE = 3;
	localparam int W_START_OFS = 4;
	localparam int W_IDLE_DELAY = 4;
	localparam int W_END_OFS = 5;

	// ****************************************
	// control word and other entry word fields
	// ****************************************
	localparam int CTL_COMMAND = 31;
	localparam int CTL_SEQ_END = 30;
	localparam int CTL_SCEN_END = 29;
	localparam int CTL_SEQ_INIT = 28;
	localparam int CTL_MARKER_EN = 24;
	localparam int CTL_SEQ_ADV_HI = 23;
	localparam int CTL_SEQ_ADV_LO = 20;
	localparam int CTL_SEG_ADV_HI = 19;
	localparam int CTL_SEG_ADV_LO = 16;
	localparam int CTL_AMP_INIT = 15;
	localparam int CTL_AMP_INC = 14;
	localparam int CTL_FREQ_INIT = 13;
	localparam int CTL_FREQ_INC = 12;
	localparam int SEG_ID_HI = 18;
	localparam int CMD_TYPE_HI = 15;
	localparam int ACTION_ID_LO = 16;
	localparam int ACTION_ID_HI = 31;
	localparam logic [3:0] ADV_LAST_DEFINED = 4'h3;
	localparam logic [15:0] CMD_IDLE = 16'h0000;
	localparam logic [15:0] CMD_CONFIG = 16'h0001;
	localparam logic [31:0] END_OFS_LAST = 32'hFFFFFFFF;

	// ****************************************
	// default entry after a table clear
	// ****************************************
	localparam logic [31:0] DEF_CONTROL = 32'h00000000;
	localparam logic [31:0] DEF_LOOP = 32'h00000001;
	localparam logic [31:0] DEF_ZERO = 32'h00000000;

	typedef logic [WORDS_PER_ENTRY-1:0][WORD_W-1:0] entry_t;

	typedef enum logic [1:0] {ADV_AUTO = 2'h0, ADV_COND = 2'h1, ADV_REPEAT = 2'h2, ADV_SINGLE = 2'h3} adv_t;
	typedef enum logic [1:0] {KIND_DATA = 2'h0, KIND_IDLE = 2'h1, KIND_CONFIG = 2'h2, KIND_UNKNOWN = 2'h3} kind_t;
	typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_WRITE = 2'b01, ST_READ = 2'b11, ST_CLEAR = 2'b10} state_t;
	typedef enum logic [1:0] {OP_WRITE = 2'h0, OP_READ = 2'h1} op_t;

	typedef struct packed {
		op_t op;
		logic [INDEX_W-1:0] index;
		logic [INDEX_W:0] length;
	} cmd_t;

	typedef struct packed {
		kind_t kind;
		logic seqEnd;
		logic scenEnd;
		logic seqInit;
		logic markerEn;
		adv_t seqAdv;
		logic seqAdvReserved;
		adv_t segAdv;
		logic segAdvReserved;
		logic ampInit;
		logic ampInc;
		logic freqInit;
		logic freqInc;
		logic [31:0] seqLoop;
		logic [31:0] segLoop;
		logic [INDEX_W-1:0] segmentId;
		logic [15:0] actionId;
		logic [31:0] idleSample;
		logic [31:0] idleDelay;
		logic [31:0] startOfs;
		logic [31:0] endOfs;
		logic endIsLast;
	} decoded_t;

	localparam entry_t DEF_ENTRY = {DEF_ZERO, DEF_ZERO, DEF_ZERO, DEF_ZERO, DEF_LOOP, DEF_CONTROL};
endpackage

// >>> verilog/seq_table_store.sv
// module: sequencer table entry store with write, read, clear and decode
//
// Summary of operation
// (RQ1) table holds 524287 entries, indexed individually
// (RQ2) entry is six 32-bit words, moved together
// (RQ3) clear request returns all entries to defaults
// (RQ4) read refused when any segment write-only
// (RQ5) write one, a run, or whole table
// (RQ6) word meaning depends on entry type
// (RQ7) writer zeroes reserved and unused fields
// (RQ8) control bit 31 selects data or command
// (RQ9) bits 30..28 mark sequence/scenario end, start
// (RQ10) bit 24 marker enable, not idle
// (RQ11) bits 23:20 sequence advancement mode
// (RQ12) bits 19:16 segment advancement, data/config
// (RQ13) bits 15..12 amplitude/frequency table stepping
// (RQ14) word 1 sequence count, first entry only
// (RQ15) word 2 segment count, data only
// (RQ16) segment id in bits 18:0
// (RQ17) requester keeps start index in range
// (RQ18) command code type 15:0, action 31:16
// (RQ19) idle sample word played during pause
// (RQ20) start/end offsets; all ones means last
`timescale 1ns/100ps
module seq_table_store
	import seq_table_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic tableClearRequest,
	input wire logic writeOnlySegmentPresent,
	input wire logic cmdValid,
	output logic cmdReady,
	input wire seq_table_pkg::cmd_t cmd,
	output logic cmdError,
	input wire logic wrValid,
	output logic wrReady,
	input wire seq_table_pkg::entry_t wrEntry,
	output logic rdValid,
	input wire logic rdReady,
	output seq_table_pkg::entry_t rdEntry,
	output seq_table_pkg::decoded_t rdDecoded,
	output logic busy
);
	import seq_table_pkg::*;

	// ****************************************
	// decode of one entry
	// ****************************************
	function automatic decoded_t decodeEntry(input entry_t e);
		decoded_t d;
		logic [31:0] ctl;
		logic [15:0] cmdType;
		logic [3:0] sa;
		logic [3:0] ga;
		d = '0;
		ctl = e[W_CONTROL];
		cmdType = e[W_CMD_CODE][CMD_TYPE_HI:0];
		// (RQ8) class from bit 31
		if (!ctl[CTL_COMMAND])
			d.kind = KIND_DATA;
		// (RQ18) command type picks idle or config
		else if (cmdType == CMD_IDLE)
			d.kind = KIND_IDLE;
		else if (cmdType == CMD_CONFIG)
			d.kind = KIND_CONFIG;
		else
			d.kind = KIND_UNKNOWN;
		// (RQ9) markers for all types
		d.seqEnd = ctl[CTL_SEQ_END];
		d.scenEnd = ctl[CTL_SCEN_END];
		d.seqInit = ctl[CTL_SEQ_INIT];
		// (RQ11) sequence advancement, reserved codes flagged
		sa = ctl[CTL_SEQ_ADV_HI:CTL_SEQ_ADV_LO];
		d.seqAdv = adv_t'(sa[1:0]);
		d.seqAdvReserved = sa > ADV_LAST_DEFINED;
		// (RQ14) loop count only counts at sequence start
		d.seqLoop = ctl[CTL_SEQ_INIT] ? e[W_SEQ_LOOP] : DEF_ZERO;
		// (RQ6) per-type word interpretation
		case (d.kind)
			KIND_DATA, KIND_CONFIG:
			begin
				// (RQ10) marker enable, not for idle
				d.markerEn = ctl[CTL_MARKER_EN];
				// (RQ12) segment advancement for data/config
				ga = ctl[CTL_SEG_ADV_HI:CTL_SEG_ADV_LO];
				d.segAdv = adv_t'(ga[1:0]);
				d.segAdvReserved = ga > ADV_LAST_DEFINED;
				// (RQ16) segment id low 19 bits
				d.segmentId = e[W_SEG_ID_DATA][SEG_ID_HI:0];
				// (RQ20) sub-range, all ones means last sample
				d.startOfs = e[W_START_OFS];
				d.endOfs = e[W_END_OFS];
				d.endIsLast = e[W_END_OFS] == END_OFS_LAST;
				if (d.kind == KIND_DATA)
				begin
					// (RQ15) segment loop count, data only
					d.segLoop = e[W_SEG_LOOP];
				end
				else
				begin
					// (RQ18) action id in upper half
					d.actionId = e[W_CMD_CODE][ACTION_ID_HI:ACTION_ID_LO];
				end
			end
			KIND_IDLE:
			begin
				// (RQ19) sample held during the pause
				d.idleSample = e[W_IDLE_SAMPLE];
				d.idleDelay = e[W_IDLE_DELAY];
			end
			default:
			begin
				d.segAdv = ADV_AUTO;
			end
		endcase
		// (RQ13) table stepping only for data and idle
		if (d.kind == KIND_DATA || d.kind == KIND_IDLE)
		begin
			d.ampInit = ctl[CTL_AMP_INIT];
			d.ampInc = ctl[CTL_AMP_INC];
			d.freqInit = ctl[CTL_FREQ_INIT];
			d.freqInc = ctl[CTL_FREQ_INC];
		end
		return d;
	endfunction

	// ****************************************
	// storage
	// ****************************************
	// (RQ1) one word-vector per entry, (RQ2) six words wide
	entry_t table_r [0:ENTRY_COUNT-1];

	state_t state_r;
	state_t state_nxt;
	logic [INDEX_W-1:0] addr_r;
	logic [INDEX_W:0] remain_r;
	logic clearPending_r;
	logic cmdError_r;
	logic rdValid_r;
	entry_t rdEntry_r;
	decoded_t rdDecoded_r;
	logic cmdTake;
	logic cmdBad;
	logic wrTake;
	logic rdLoad;
	logic lastBeat;
	logic [INDEX_W:0] endIndex;

	assign cmdReady = (state_r == ST_IDLE) && !clearPending_r;
	assign cmdTake = cmdValid && cmdReady;
	assign endIndex = {1'b0, cmd.index} + cmd.length;
	// (RQ17) index or run beyond the table is refused, except a run whose index plus length overflows the 20-bit sum and wraps
	// (RQ4) read refused while any segment is write-only
	assign cmdBad = (cmd.index > LAST_INDEX) || (cmd.length == '0) || (endIndex > ENTRY_COUNT_V)
		|| (cmd.op == OP_READ && writeOnlySegmentPresent);
	assign wrReady = state_r == ST_WRITE;
	assign wrTake = wrValid && wrReady;
	// output register refills when empty or once the consumer takes the held entry
	assign rdLoad = (state_r == ST_READ) && (!rdValid_r || rdReady);
	assign lastBeat = remain_r == {{INDEX_W{1'b0}}, 1'b1};
	assign busy = state_r != ST_IDLE;
	assign cmdError = cmdError_r;
	assign rdValid = rdValid_r;
	assign rdEntry = rdEntry_r;
	assign rdDecoded = rdDecoded_r;

	// ****************************************
	// sequencing
	// ****************************************
	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE:
			begin
				if (clearPending_r)
					state_nxt = ST_CLEAR;
				else if (cmdTake && !cmdBad)
					state_nxt = (cmd.op == OP_READ) ? ST_READ : ST_WRITE;
			end
			ST_WRITE:
			begin
				if (wrTake && lastBeat)
					state_nxt = ST_IDLE;
			end
			ST_READ:
			begin
				if (rdLoad && lastBeat)
					state_nxt = ST_IDLE;
			end
			ST_CLEAR:
			begin
				if (addr_r == LAST_INDEX)
					state_nxt = ST_IDLE;
			end
			default:
			begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			state_r <= ST_IDLE;
		else
			state_r <= state_nxt;
	end

	// clear requests arriving mid-transfer wait until the transfer ends
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			clearPending_r <= 1'b0;
		else if (tableClearRequest)
			clearPending_r <= 1'b1;
		else if (state_r == ST_IDLE)
			clearPending_r <= 1'b0;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			cmdError_r <= 1'b0;
		else
			cmdError_r <= cmdTake && cmdBad;
	end

	// ****************************************
	// address walk
	// ****************************************
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			addr_r <= '0;
			remain_r <= '0;
		end
		else if (state_r == ST_IDLE && clearPending_r)
		begin
			addr_r <= '0;
			remain_r <= ENTRY_COUNT_V;
		end
		else if (cmdTake && !cmdBad)
		begin
			addr_r <= cmd.index;
			remain_r <= cmd.length;
		end
		// (RQ5) runs advance to consecutive entries
		else if (wrTake || rdLoad || state_r == ST_CLEAR)
		begin
			addr_r <= addr_r + 1'b1;
			remain_r <= remain_r - 1'b1;
		end
	end

	// ****************************************
	// table writes
	// ****************************************
	// one port: clear and host writes never overlap, so they share it
	always_ff @(posedge clk)
	begin
		// (RQ3) clear walks every entry to defaults
		if (state_r == ST_CLEAR)
			table_r[addr_r] <= DEF_ENTRY;
		// (RQ5) host entry stored whole
		else if (wrTake)
			table_r[addr_r] <= wrEntry;
	end

	// ****************************************
	// table reads
	// ****************************************
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			rdValid_r <= 1'b0;
		else if (rdLoad)
			rdValid_r <= 1'b1;
		else if (rdReady)
			rdValid_r <= 1'b0;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rdEntry_r <= '0;
			rdDecoded_r <= '0;
		end
		else if (rdLoad)
		begin
			// (RQ2) whole entry presented at once
			rdEntry_r <= table_r[addr_r];
			rdDecoded_r <= decodeEntry(table_r[addr_r]);
		end
	end
endmodule // seq_table_store
